// file: shared/rhpm_regs.svh
`ifndef RHPM_REGS_SVH
`define RHPM_REGS_SVH

// Bus geometry
`define RHPM_ADDR_W 8
`define RHPM_DATA_W 32

// Register byte offsets
`define RHPM_CTRL_OFS 8'h00
`define RHPM_GPIO_OFS 8'h04
`define RHPM_STAT_OFS 8'h08

// Register index codes returned by the decoder
`define RHPM_IDX_NONE 2'h0
`define RHPM_IDX_CTRL 2'h1
`define RHPM_IDX_GPIO 2'h2
`define RHPM_IDX_STAT 2'h3

// Field widths and reset values
`define RHPM_CTRL_W 5
`define RHPM_CTRL_RST 5'h00
`define RHPM_GPIO_W 2
`define RHPM_GPIO_RST 2'h0
`define RHPM_STAT_W 8

// AXI responses
`define RHPM_RESP_OKAY 2'h0
`define RHPM_RESP_SLVERR 2'h2

// Width of the pad input group that passes the synchroniser
`define RHPM_PAD_IN_W 11

`endif

// file: shared/rhpm_pkg.sv
`default_nettype none
package rhpm_pkg;

  typedef enum logic {RT_LINK, RT_AUDIO} rhpm_route_t;

  // Control register, bit 0 is the routing select
  typedef struct packed {
    logic gpio0_alert_sel;
    logic short_pd_dis;
    logic wlan_pd_dis;
    logic audio_master;
    logic audio_route;
  } rhpm_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
  } rhpm_pin_t;

  // Drives for every shared pad
  typedef struct packed {
    rhpm_pin_t host_link_request_to_send_out;
    rhpm_pin_t host_link_clear_to_send_in;
    rhpm_pin_t radio_to_host_alert;
    rhpm_pin_t radio_wake_request_in;
    rhpm_pin_t audio_port_clock_pin;
    rhpm_pin_t audio_port_word_select_pin;
    rhpm_pin_t audio_port_data_out_pin;
    rhpm_pin_t gpio0_pin;
    logic host_link_serial_out;
  } rhpm_pads_out_t;

  // Levels seen on the pads, before synchronising
  typedef struct packed {
    logic host_link_request_to_send_out;
    logic host_link_clear_to_send_in;
    logic radio_to_host_alert;
    logic radio_wake_request_in;
    logic host_link_serial_in;
    logic audio_port_clock_pin;
    logic audio_port_word_select_pin;
    logic audio_port_data_in_pin;
    logic wlan_power_enable;
    logic short_radio_power_enable;
    logic gpio0_pin;
  } rhpm_pads_in_t;

  // Internal serial link controller toward the mux
  typedef struct packed {
    logic txd;
    logic rts_assert;
    logic busy;
    logic radio_alert;
    logic wlan_alert;
  } rhpm_link_req_t;

  // Mux toward the internal serial link controller
  typedef struct packed {
    logic rxd;
    logic cts_ok;
    logic dev_wake;
    logic three_wire_sleep;
  } rhpm_link_ind_t;

  // Internal audio port toward the mux
  typedef struct packed {
    logic clk;
    logic sync;
    logic dout;
    logic busy;
  } rhpm_audio_req_t;

  // Mux toward the internal audio port
  typedef struct packed {
    logic clk;
    logic sync;
    logic din;
  } rhpm_audio_ind_t;

  // Power manager controls per section
  typedef struct packed {
    logic wlan_reg_on;
    logic wlan_hold_reset;
    logic wlan_pulldown_en;
    logic short_reg_on;
    logic short_hold_reset;
    logic short_pulldown_en;
  } rhpm_power_t;

endpackage
`default_nettype wire

// file: rtl/rhpm_top.sv
// Overview of operation
// - Reset gives wake and link pins defaults
// - Audio select puts PCM on four pins
// - Rerouted audio means three-wire in-band sleep
// - Clear-to-send low means host allows sending
// - Request-to-send driven low asserts, high deasserts
// - Audio clock and sync drive only as master
// - WLAN enable switches WLAN regulators
// - WLAN enable low holds WLAN in reset
// - Short radio enable switches regulators and reset
// - Enable pull-downs on after reset, software-disable
// - GPIO0 becomes output as WLAN host alert
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`include "rhpm_regs.svh"
`default_nettype none
module rhpm_top
  import rhpm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [`RHPM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`RHPM_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`RHPM_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`RHPM_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pads
  input wire rhpm_pads_in_t pads_in,
  output rhpm_pads_out_t pads_out,
  // Internal serial link controller
  input wire rhpm_link_req_t link_req,
  output rhpm_link_ind_t link_ind,
  // Internal audio port
  input wire rhpm_audio_req_t audio_req,
  output rhpm_audio_ind_t audio_ind,
  // Power manager
  output rhpm_power_t power
);

  // Decoder shared by the read and write paths
  function automatic logic [1:0] reg_index(input logic [`RHPM_ADDR_W-1:0] a);
    if (a == `RHPM_CTRL_OFS) begin
      reg_index = `RHPM_IDX_CTRL;
    end else if (a == `RHPM_GPIO_OFS) begin
      reg_index = `RHPM_IDX_GPIO;
    end else if (a == `RHPM_STAT_OFS) begin
      reg_index = `RHPM_IDX_STAT;
    end else begin
      reg_index = `RHPM_IDX_NONE;
    end
  endfunction

  // Pad synchroniser: first stage feeds only the second
  logic [`RHPM_PAD_IN_W-1:0] meta_r, meta_nxt;
  logic [`RHPM_PAD_IN_W-1:0] sync_r, sync_nxt;
  rhpm_pads_in_t pin_s;

  always_comb begin
    meta_nxt = pads_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign pin_s = rhpm_pads_in_t'(sync_r);

  // Software state
  rhpm_ctrl_t ctrl_r, ctrl_nxt;
  rhpm_pin_t gpio_r, gpio_nxt;
  rhpm_route_t route_r, route_nxt;
  logic [`RHPM_STAT_W-1:0] status;

  // AXI slave state
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [`RHPM_DATA_W-1:0] rdata_r, rdata_nxt;
  logic aw_got_r, aw_got_nxt;
  logic w_got_r, w_got_nxt;
  logic [`RHPM_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [`RHPM_DATA_W-1:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic hs_aw, hs_w, hs_ar;
  logic [`RHPM_ADDR_W-1:0] wa;
  logic [`RHPM_DATA_W-1:0] wd;
  logic wlane;

  assign hs_aw = s_axi_awvalid && awready_r;
  assign hs_w = s_axi_wvalid && wready_r;
  assign hs_ar = s_axi_arvalid && arready_r;
  assign wa = hs_aw ? s_axi_awaddr : awaddr_r;
  assign wd = hs_w ? s_axi_wdata : wdata_r;
  assign wlane = hs_w ? s_axi_wstrb[0] : wstrb0_r;

  // Address and data taken in either order; the write lands once both are in
  always_comb begin
    aw_got_nxt = aw_got_r || hs_aw;
    w_got_nxt = w_got_r || hs_w;
    awaddr_nxt = wa;
    wdata_nxt = wd;
    wstrb0_nxt = wlane;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    ctrl_nxt = ctrl_r;
    gpio_nxt = gpio_r;
    if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `RHPM_RESP_OKAY;
      if (reg_index(wa) == `RHPM_IDX_CTRL) begin
        if (wlane) begin
          ctrl_nxt = rhpm_ctrl_t'(wd[`RHPM_CTRL_W-1:0]);
        end
      end else if (reg_index(wa) == `RHPM_IDX_GPIO) begin
        if (wlane) begin
          gpio_nxt = rhpm_pin_t'(wd[`RHPM_GPIO_W-1:0]);
        end
      end else if (reg_index(wa) == `RHPM_IDX_STAT) begin
        bresp_nxt = `RHPM_RESP_OKAY;
      end else begin
        bresp_nxt = `RHPM_RESP_SLVERR;
      end
    end
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt = !w_got_nxt && !bvalid_nxt;
  end

  // Read answers one cycle after the address is taken
  always_comb begin
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (hs_ar) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `RHPM_RESP_OKAY;
      rdata_nxt = '0;
      if (reg_index(s_axi_araddr) == `RHPM_IDX_CTRL) begin
        rdata_nxt[`RHPM_CTRL_W-1:0] = ctrl_r;
      end else if (reg_index(s_axi_araddr) == `RHPM_IDX_GPIO) begin
        rdata_nxt[`RHPM_GPIO_W-1:0] = gpio_r;
      end else if (reg_index(s_axi_araddr) == `RHPM_IDX_STAT) begin
        rdata_nxt[`RHPM_STAT_W-1:0] = status;
      end else begin
        rresp_nxt = `RHPM_RESP_SLVERR;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RHPM_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `RHPM_RESP_OKAY;
      rdata_r <= '0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      // link routing and enabled pull-downs after reset
      ctrl_r <= rhpm_ctrl_t'(`RHPM_CTRL_RST);
      gpio_r <= rhpm_pin_t'(`RHPM_GPIO_RST);
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      ctrl_r <= ctrl_nxt;
      gpio_r <= gpio_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Routing follows the select only between symbols, never mid-frame
  always_comb begin
    route_nxt = route_r;
    case (route_r)
      RT_LINK: begin
        if (ctrl_r.audio_route && !link_req.busy && !audio_req.busy) begin
          route_nxt = RT_AUDIO;
        end
      end
      RT_AUDIO: begin
        if (!ctrl_r.audio_route && !link_req.busy && !audio_req.busy) begin
          route_nxt = RT_LINK;
        end
      end
      default: begin
        route_nxt = RT_LINK;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_r <= RT_LINK;
    end else begin
      route_r <= route_nxt;
    end
  end

  assign status = {pin_s.radio_to_host_alert,
                   pin_s.radio_wake_request_in,
                   pin_s.gpio0_pin,
                   !pin_s.host_link_clear_to_send_in,
                   pin_s.short_radio_power_enable,
                   pin_s.wlan_power_enable,
                   ctrl_r.audio_route != (route_r == RT_AUDIO),
                   route_r == RT_AUDIO};

  // Pad and core-side outputs, all registered
  rhpm_pads_out_t pads_r, pads_nxt;
  rhpm_link_ind_t link_r, link_nxt;
  rhpm_audio_ind_t audio_r, audio_nxt;
  rhpm_power_t power_r, power_nxt;

  always_comb begin
    pads_nxt = '0;
    link_nxt = '0;
    audio_nxt = '0;
    pads_nxt.host_link_serial_out = link_req.txd;
    link_nxt.rxd = pin_s.host_link_serial_in;
    if (route_r == RT_LINK) begin
      // flow control and wake functions on shared pads
      pads_nxt.host_link_request_to_send_out = '{o: !link_req.rts_assert, oe: 1'b1};
      pads_nxt.radio_to_host_alert = '{o: link_req.radio_alert, oe: 1'b1};
      link_nxt.cts_ok = !pin_s.host_link_clear_to_send_in;
      link_nxt.dev_wake = pin_s.radio_wake_request_in;
      // clock and sync driven only as master
      pads_nxt.audio_port_clock_pin = '{o: audio_req.clk, oe: ctrl_r.audio_master};
      pads_nxt.audio_port_word_select_pin = '{o: audio_req.sync, oe: ctrl_r.audio_master};
      pads_nxt.audio_port_data_out_pin = '{o: audio_req.dout, oe: 1'b1};
      audio_nxt.clk = ctrl_r.audio_master ? audio_req.clk : pin_s.audio_port_clock_pin;
      audio_nxt.sync = ctrl_r.audio_master ? audio_req.sync : pin_s.audio_port_word_select_pin;
      audio_nxt.din = pin_s.audio_port_data_in_pin;
    end else begin
      // clock, data out, sync, data in on shared pads
      // clock and sync driven only as master
      pads_nxt.host_link_request_to_send_out = '{o: audio_req.clk, oe: ctrl_r.audio_master};
      pads_nxt.host_link_clear_to_send_in = '{o: audio_req.dout, oe: 1'b1};
      pads_nxt.radio_to_host_alert = '{o: audio_req.sync, oe: ctrl_r.audio_master};
      audio_nxt.clk = ctrl_r.audio_master ? audio_req.clk
                                          : pin_s.host_link_request_to_send_out;
      audio_nxt.sync = ctrl_r.audio_master ? audio_req.sync : pin_s.radio_to_host_alert;
      audio_nxt.din = pin_s.radio_wake_request_in;
      // three-wire sleep, no pad flow control
      link_nxt.cts_ok = 1'b1;
      link_nxt.three_wire_sleep = 1'b1;
    end
    // GPIO0 output as WLAN host alert
    if (ctrl_r.gpio0_alert_sel) begin
      pads_nxt.gpio0_pin = '{o: link_req.wlan_alert, oe: 1'b1};
    end else begin
      pads_nxt.gpio0_pin = gpio_r;
    end
  end

  always_comb begin
    power_nxt.wlan_reg_on = pin_s.wlan_power_enable;
    // WLAN held in reset while disabled
    power_nxt.wlan_hold_reset = !pin_s.wlan_power_enable;
    power_nxt.short_reg_on = pin_s.short_radio_power_enable;
    power_nxt.short_hold_reset = !pin_s.short_radio_power_enable;
    power_nxt.wlan_pulldown_en = !ctrl_r.wlan_pd_dis;
    power_nxt.short_pulldown_en = !ctrl_r.short_pd_dis;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pads_r <= '0;
      link_r <= '0;
      audio_r <= '0;
      // Sections stay held and pull-downs on until the pads are sampled
      power_r <= '{wlan_reg_on: 1'b0, wlan_hold_reset: 1'b1, wlan_pulldown_en: 1'b1,
                   short_reg_on: 1'b0, short_hold_reset: 1'b1, short_pulldown_en: 1'b1};
    end else begin
      pads_r <= pads_nxt;
      link_r <= link_nxt;
      audio_r <= audio_nxt;
      power_r <= power_nxt;
    end
  end

  assign pads_out = pads_r;
  assign link_ind = link_r;
  assign audio_ind = audio_r;
  assign power = power_r;

endmodule
`default_nettype wire

// file: testbench/rhpm_top_sva.sv
`default_nettype none
module rhpm_top_sva
  import rhpm_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pads and core sides
  input wire rhpm_pads_in_t pads_in,
  input wire rhpm_pads_out_t pads_out,
  input wire rhpm_link_req_t link_req,
  input wire rhpm_link_ind_t link_ind,
  input wire rhpm_audio_req_t audio_req,
  input wire rhpm_power_t power
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic tws = link_ind.three_wire_sleep;
  wire rhpm_pin_t rts = pads_out.host_link_request_to_send_out;
  wire rhpm_pin_t cts = pads_out.host_link_clear_to_send_in;
  wire rhpm_pin_t alrt = pads_out.radio_to_host_alert;
  // Synchroniser history must be clean for three edges before pad checks
  logic [2:0] up_r = 3'h0;
  always @(posedge aclk) up_r <= {up_r[1:0], aresetn};

  property p_rst_route;
    $rose(aresetn) |=> !tws && rts.oe && !cts.oe;
  endproperty
  a_rst_route: assert property (p_rst_route) else $error("routing not default");
  property p_pd_rst;
    $rose(aresetn) |=> power.wlan_pulldown_en && power.short_pulldown_en;
  endproperty
  a_pd_rst: assert property (p_pd_rst) else $error("pull-downs off after reset");
  property p_wlan;
    up_r == 3'h7 |-> power.wlan_reg_on == $past(pads_in.wlan_power_enable, 3)
      && power.wlan_hold_reset == !$past(pads_in.wlan_power_enable, 3);
  endproperty
  a_wlan: assert property (p_wlan) else $error("wlan power wrong");
  property p_short;
    up_r == 3'h7 |-> power.short_reg_on == $past(pads_in.short_radio_power_enable, 3)
      && power.short_hold_reset == !$past(pads_in.short_radio_power_enable, 3);
  endproperty
  a_short: assert property (p_short) else $error("short radio power wrong");
  property p_cts_link;
    !tws [*4] |-> link_ind.cts_ok == !$past(pads_in.host_link_clear_to_send_in, 3);
  endproperty
  a_cts_link: assert property (p_cts_link) else $error("clear-to-send polarity");
  property p_rts_link;
    !tws [*3] |-> rts == {!$past(link_req.rts_assert), 1'h1};
  endproperty
  a_rts_link: assert property (p_rts_link) else $error("request-to-send polarity");
  property p_audio_pads;
    tws [*3] |-> cts == {$past(audio_req.dout), 1'h1} && rts.o == $past(audio_req.clk)
      && alrt.o == $past(audio_req.sync);
  endproperty
  a_audio_pads: assert property (p_audio_pads) else $error("audio pad mapping");
  property p_dir;
    tws [*3] |-> rts.oe == alrt.oe && !pads_out.audio_port_clock_pin.oe
      && !pads_out.audio_port_word_select_pin.oe;
  endproperty
  a_dir: assert property (p_dir) else $error("audio clock direction");
  property p_sleep;
    tws && $past(tws) |-> link_ind.cts_ok && !link_ind.dev_wake;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not in-band");
  property p_idle_switch;
    $changed(tws) |-> !($past(link_req.busy) || $past(audio_req.busy))
      || !($past(link_req.busy, 2) || $past(audio_req.busy, 2));
  endproperty
  a_idle_switch: assert property (p_idle_switch) else $error("switched while busy");
endmodule

bind rhpm_top rhpm_top_sva u_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .pads_in(pads_in),
  .pads_out(pads_out),
  .link_req(link_req),
  .link_ind(link_ind),
  .audio_req(audio_req),
  .power(power)
);
`default_nettype wire

// file: testbench/rhpm_host_model.sv
`default_nettype none
module rhpm_host_model
  import rhpm_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Device side
  input wire rhpm_pads_out_t pads_out,
  input wire rhpm_power_t power,
  // Host intent: {float enables, short en, wlan en, rxd, wake or pcm in, cts}
  input wire logic rerouted,
  input wire logic [5:0] host_drv,
  // Resolved pad levels
  output rhpm_pads_in_t pads_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released lines wander so a stale level is never mistaken for a drive
  logic wander_r = 1'h0;
  always @(posedge aclk) wander_r <= ~wander_r;
  function automatic logic lvl(rhpm_pin_t p, logic alt);
    return p.oe ? p.o : alt;
  endfunction
  always_comb begin
    pads_in.host_link_request_to_send_out = lvl(pads_out.host_link_request_to_send_out, wander_r);
    pads_in.host_link_clear_to_send_in =
      lvl(pads_out.host_link_clear_to_send_in, rerouted ? wander_r : host_drv[0]);
    pads_in.radio_to_host_alert = lvl(pads_out.radio_to_host_alert, wander_r);
    pads_in.radio_wake_request_in = host_drv[1];
    pads_in.host_link_serial_in = host_drv[2];
    pads_in.audio_port_clock_pin = lvl(pads_out.audio_port_clock_pin, wander_r);
    pads_in.audio_port_word_select_pin = lvl(pads_out.audio_port_word_select_pin, wander_r);
    pads_in.audio_port_data_in_pin = ~wander_r;
    pads_in.wlan_power_enable =
      host_drv[5] ? (power.wlan_pulldown_en ? 1'h0 : wander_r) : host_drv[3];
    pads_in.short_radio_power_enable =
      host_drv[5] ? (power.short_pulldown_en ? 1'h0 : wander_r) : host_drv[4];
    pads_in.gpio0_pin = lvl(pads_out.gpio0_pin, wander_r);
  end
endmodule
`default_nettype wire

// file: testbench/radio_host_pin_mux_and_power_enables_test.sv
`include "rhpm_regs.svh"
`default_nettype none
module radio_host_pin_mux_and_power_enables_test;
  import rhpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rhpm_pads_in_t pads_in;
  rhpm_pads_out_t pads_out;
  rhpm_link_req_t link_req = '0;
  rhpm_link_ind_t link_ind;
  rhpm_audio_req_t audio_req = '0;
  rhpm_audio_ind_t audio_ind;
  rhpm_power_t power;
  logic rerouted = 1'h0;
  logic [5:0] host_drv = 6'h00;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  wire rhpm_pin_t rts = pads_out.host_link_request_to_send_out;
  wire rhpm_pin_t cts = pads_out.host_link_clear_to_send_in;
  wire rhpm_pin_t alrt = pads_out.radio_to_host_alert;

  always #25 aclk = ~aclk;

  rhpm_top DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pads_in(pads_in), .pads_out(pads_out),
    .link_req(link_req), .link_ind(link_ind), .audio_req(audio_req),
    .audio_ind(audio_ind), .power(power)
  );

  rhpm_host_model u_host (
    .aclk(aclk), .pads_out(pads_out), .power(power), .rerouted(rerouted),
    .host_drv(host_drv), .pads_in(pads_in)
  );

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    @(posedge aclk);
    n = 0;
    done = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        done = 1'h1;
        bready <= 1'h0;
        chk("bresp", er, bresp);
      end
    end
    if (!done) chk("bus_wait", 32'h0, 32'h1);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    logic done;
    @(posedge aclk);
    n = 0;
    done = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        done = 1'h1;
        rready <= 1'h0;
        chk("rresp", er, rresp);
        chk("rdata", e, rdata & m);
      end
    end
    if (!done) chk("bus_wait", 32'h0, 32'h1);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    settle(20);
    aresetn <= 1'h1;
    settle(4);
    chk("rts_oe", 1'h1, rts.oe);
    chk("cts_oe", 1'h0, cts.oe);
    chk("ded_oe", 3'h1, {pads_out.audio_port_clock_pin.oe,
                         pads_out.audio_port_word_select_pin.oe,
                         pads_out.audio_port_data_out_pin.oe});
    chk("pd_en", 2'h3, {power.wlan_pulldown_en, power.short_pulldown_en});
    rc(`RHPM_CTRL_OFS, 32'hFFFFFFFF, 32'h0, `RHPM_RESP_OKAY);
    rc(`RHPM_GPIO_OFS, 32'hFFFFFFFF, 32'h0, `RHPM_RESP_OKAY);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      link_req.rts_assert <= i[0];
      link_req.txd <= i[0];
      link_req.radio_alert <= !i[0];
      host_drv[0] <= i[0];
      host_drv[2:1] <= {i[0], !i[0]};
      settle(5);
      chk("rts", {!i[0], 1'h1}, rts);
      chk("link_out", {i[0], !i[0], 1'h1}, {pads_out.host_link_serial_out, alrt});
      chk("link_in", {i[0], !i[0]}, {link_ind.rxd, link_ind.dev_wake});
      chk("cts_ok", !i[0], link_ind.cts_ok);
      rc(`RHPM_STAT_OFS, 32'h10, i[0] ? 32'h0 : 32'h10, `RHPM_RESP_OKAY);
    end
    $display("test link done");
    for (int i = 0; i < 4; i++) begin
      host_drv[4:3] <= i[1:0];
      settle(5);
      chk("wlan", {i[0], !i[0]}, {power.wlan_reg_on, power.wlan_hold_reset});
      chk("short", {i[1], !i[1]}, {power.short_reg_on, power.short_hold_reset});
      rc(`RHPM_STAT_OFS, 32'hC, {28'h0, i[1:0], 2'h0}, `RHPM_RESP_OKAY);
    end
    host_drv[5] <= 1'h1;
    settle(5);
    chk("float", 2'h0, {power.wlan_reg_on, power.short_reg_on});
    host_drv[5] <= 1'h0;
    wr(`RHPM_CTRL_OFS, 32'hC, `RHPM_RESP_OKAY);
    settle(2);
    chk("pd_dis", 2'h0, {power.wlan_pulldown_en, power.short_pulldown_en});
    $display("test power done");
    wr(`RHPM_GPIO_OFS, 32'h3, `RHPM_RESP_OKAY);
    settle(2);
    chk("gpio0", 2'h3, pads_out.gpio0_pin);
    link_req.wlan_alert <= 1'h1;
    wr(`RHPM_CTRL_OFS, 32'h10, `RHPM_RESP_OKAY);
    wr(`RHPM_GPIO_OFS, 32'h0, `RHPM_RESP_OKAY);
    settle(2);
    chk("gpio0", 2'h3, pads_out.gpio0_pin);
    wr(`RHPM_CTRL_OFS, 32'h0, `RHPM_RESP_OKAY);
    settle(2);
    chk("gpio0", 2'h0, pads_out.gpio0_pin);
    wr(8'h40, 32'h1, `RHPM_RESP_SLVERR);
    rc(8'h40, 32'hFFFFFFFF, 32'h0, `RHPM_RESP_SLVERR);
    wr(`RHPM_STAT_OFS, 32'hFF, `RHPM_RESP_OKAY);
    rc(`RHPM_CTRL_OFS, 32'hFFFFFFFF, 32'h0, `RHPM_RESP_OKAY);
    $display("test gpio and bus done");
    link_req.busy <= 1'h1;
    rerouted <= 1'h1;
    wr(`RHPM_CTRL_OFS, 32'h3, `RHPM_RESP_OKAY);
    settle(5);
    chk("sleep", 1'h0, link_ind.three_wire_sleep);
    rc(`RHPM_STAT_OFS, 32'h3, 32'h2, `RHPM_RESP_OKAY);
    audio_req <= '{clk: 1'h1, sync: 1'h0, dout: 1'h1, busy: 1'h1};
    link_req.busy <= 1'h0;
    settle(5);
    chk("sleep", 1'h0, link_ind.three_wire_sleep);
    audio_req.busy <= 1'h0;
    settle(5);
    chk("sleep", 1'h1, link_ind.three_wire_sleep);
    chk("cts_ok", 1'h1, link_ind.cts_ok);
    chk("pcm_pads", 6'h3D, {rts, cts, alrt});
    host_drv[1] <= 1'h1;
    settle(5);
    chk("pcm_in", 1'h1, audio_ind.din);
    chk("pcm_ind", 2'h2, {audio_ind.clk, audio_ind.sync});
    wr(`RHPM_CTRL_OFS, 32'h1, `RHPM_RESP_OKAY);
    settle(2);
    chk("slave_oe", 2'h0, {rts.oe, alrt.oe});
    wr(`RHPM_CTRL_OFS, 32'h2, `RHPM_RESP_OKAY);
    rerouted <= 1'h0;
    settle(5);
    chk("sleep", 1'h0, link_ind.three_wire_sleep);
    chk("clk_oe", 2'h3, {pads_out.audio_port_clock_pin.oe,
                         pads_out.audio_port_word_select_pin.oe});
    $display("test routing done");
    summarize();
  end
endmodule
`default_nettype wire
